// ### pkg/dual_pot_pkg.sv
package dual_pot_pkg;
   // ==========================================
   // Sizes
   localparam int CODE_W = 10;
   localparam int TAP_COUNT = 1024;
   localparam int NV_WORDS = 16;
   localparam logic [4:0] BIT_CNT_LAST = 5'h17;

   // ==========================================
   // Wiper codes
   localparam logic [9:0] CODE_ZERO = 10'h000;
   localparam logic [9:0] CODE_ONE = 10'h001;
   localparam logic [9:0] CODE_MID = 10'h200;
   localparam logic [9:0] CODE_FULL = 10'h3FF;

   // ==========================================
   // Instruction nibbles
   localparam logic [3:0] OP_NOP = 4'h0;
   localparam logic [3:0] OP_RECALL = 4'h1;
   localparam logic [3:0] OP_SAVE = 4'h2;
   localparam logic [3:0] OP_USER_STORE = 4'h3;
   localparam logic [3:0] OP_RECALL_ALL = 4'h8;
   localparam logic [3:0] OP_READ_NV = 4'h9;
   localparam logic [3:0] OP_READ_WIPER = 4'hA;
   localparam logic [3:0] OP_WRITE_WIPER = 4'hB;
   localparam logic [3:0] OP_SHIFT_LEFT = 4'hC;
   localparam logic [3:0] OP_INC_STEP = 4'hE;

   // ==========================================
   // Nonvolatile word addresses
   localparam logic [3:0] ADDR_CH1 = 4'h0;
   localparam logic [3:0] ADDR_CH2 = 4'h1;
   localparam logic [3:0] ADDR_USER_FIRST = 4'h2;
   localparam logic [3:0] ADDR_USER_LAST = 4'hE;
   localparam logic [3:0] ADDR_TOLERANCE = 4'hF;

   // ==========================================
   // Reset values
   localparam logic [15:0] NV_RESET = 16'h0000;
   // Arbitrary value
   localparam logic [15:0] TOLERANCE_RESET = 16'h0000;
   localparam logic [2:0] SYNC_HIGH = 3'h7;
   localparam logic [2:0] SYNC_LOW = 3'h0;
   localparam logic [TAP_COUNT-1:0] TAP_RESET = {{(TAP_COUNT-1){1'b0}}, 1'b1};

   // ==========================================
   // Types
   typedef logic [CODE_W-1:0] code_t;
   typedef struct packed {
      logic [3:0] op;
      logic [3:0] addr;
      logic [15:0] data;
   } frame_s;
endpackage : dual_pot_pkg

// ### src/serial_frame_link.sv
`timescale 1ns/100ps
`default_nettype none
module serial_frame_link
   import dual_pot_pkg::*;
(
   input wire logic sclk,
   input wire logic rst,
   input wire logic csN,
   input wire logic sdi,
   input wire frame_s replyWord,
   output var frame_s rxWord,
   output var logic frameTog,
   output var logic sdo
);
   typedef struct packed {
      frame_s shift;
      logic tog;
   } link_s;

   link_s link_reg;
   link_s link_next;
   logic [4:0] bitCnt_reg;
   logic [4:0] bitCnt_next;
   logic sdo_reg;
   logic sdo_next;
   logic [23:0] replyBits;

   // ==========================================
   // Receive shifter
   assign replyBits = replyWord;

   always_comb
   begin
      link_next = link_reg;
      bitCnt_next = bitCnt_reg;
      if (!csN)
      begin
         link_next.shift = {link_reg.shift[22:0], sdi}; // R20
         bitCnt_next = bitCnt_reg + 5'h01;
         if (bitCnt_reg == BIT_CNT_LAST)
         begin
            bitCnt_next = 5'h00;
            link_next.tog = ~link_reg.tog; // R20
         end
      end
      if (bitCnt_reg == 5'h00)
         sdo_next = link_reg.shift.op[3];
      else
         sdo_next = replyBits[BIT_CNT_LAST - bitCnt_reg]; // R16
   end

   always_ff @(posedge sclk or posedge rst)
   begin
      if (rst)
         link_reg <= '0;
      else
         link_reg <= link_next;
   end

   always_ff @(posedge sclk or posedge rst or posedge csN)
   begin
      if (rst)
         bitCnt_reg <= 5'h00;
      else if (csN)
         bitCnt_reg <= 5'h00; // R20
      else
         bitCnt_reg <= bitCnt_next;
   end

   always_ff @(negedge sclk or posedge rst)
   begin
      if (rst)
         sdo_reg <= 1'b0;
      else
         sdo_reg <= sdo_next;
   end

   assign rxWord = link_reg.shift;
   assign frameTog = link_reg.tog;
   assign sdo = sdo_reg;

   // ==========================================
   // Checks
   chk_frame_complete: assert property (@(posedge sclk) disable iff (rst) // R20
      (!csN && bitCnt_reg == BIT_CNT_LAST) |=> (link_reg.tog != $past(link_reg.tog)))
      else $error("frame toggle missed after last bit");
endmodule : serial_frame_link
`default_nettype wire

// ### src/dual_pot_serial_command_core.sv
// Notes on behaviour
// (R1) Each channel holds a 10-bit code selecting exactly one of 1024 taps.
// (R2) Code zero is the B end; each step up moves one tap toward A.
// (R3) Instruction 0xB writes low 10 data bits to channel 0 or 1.
// (R4) Instruction 0xE0 raises channel one code by exactly one step.
// (R5) Instruction 0x20 saves a wiper code into the first saved word.
// (R6) Write-protect low blocks every change of the nonvolatile words.
// (R7) Codes reload from saved words at reset, recall strobe and recall command.
// (R8) Instruction 0x10 loads channel one from the first saved word.
// (R9) Host sends a no-operation frame after recall or read preparation.
// (R10) Instructions 0xC0 and 0xC1 double channel one or two code.
// (R11) Doubling midscale yields full scale, never overflow.
// (R12) Instruction 0x3 stores 16 data bits into a spare word, address 2 up; only addresses 2 to 14 are accepted.
// (R13) Instruction 0x9 prepares a read of the addressed nonvolatile word.
// (R14) Next frame shifts out 24 bits, last 16 hold contents; no-op idles.
// (R15) Instruction 0xA0 prepares readback of the channel one code.
// (R16) Output echoes previous instruction and address; reads replace data.
// (R17) Doubling a code at or above midscale gives full scale.
// (R18) Doubling a zero code gives one.
// (R19) Chip-select strobe without clocks repeats the last command.
// (R20) Frames are 24 bits MSB first; execution on chip-select rising.
// (R21) Incrementing at full scale leaves the code unchanged.
`timescale 1ns/100ps
`default_nettype none
module dual_pot_serial_command_core
   import dual_pot_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic sclk,
   input wire logic csN,
   input wire logic sdi,
   output var logic sdo,
   input wire logic recallStrobeN,
   input wire logic writeProtectN,
   output var code_t wiperCode1,
   output var code_t wiperCode2,
   output var logic [TAP_COUNT-1:0] tapSelect1,
   output var logic [TAP_COUNT-1:0] tapSelect2,
   output var logic readPowerActive
);
   typedef enum logic {ST_BOOT, ST_IDLE} core_state_e;

   typedef struct packed {
      core_state_e state;
      logic [2:0] csSync;
      logic [2:0] togSync;
      logic [2:0] recSync;
      logic [2:0] wpSync;
      logic csLvl;
      logic togLvl;
      logic recLvl;
      logic wpLvl;
      logic togSeen;
      frame_s cmd;
      frame_s reply;
      logic [1:0][CODE_W-1:0] wiper;
      logic [1:0][TAP_COUNT-1:0] tap;
      logic [NV_WORDS-1:0][15:0] nv;
      logic readPower;
   } core_s;

   core_s core_reg;
   core_s core_next;
   frame_s rxWord;
   logic frameTog;
   logic csRise;
   logic newFrame;
   logic recallFall;
   logic execNow;
   frame_s execCmd;
   logic chSel;
   logic chValid;
   logic userAddr;

   // ==========================================
   // Link side
   serial_frame_link u_link (
      .sclk(sclk),
      .rst(rst),
      .csN(csN),
      .sdi(sdi),
      .replyWord(core_reg.reply),
      .rxWord(rxWord),
      .frameTog(frameTog),
      .sdo(sdo)
   );

   // ==========================================
   // Helpers
   function automatic logic sync_level(input logic [2:0] s, input logic lvl);
      return (s[1] == s[2]) ? s[2] : lvl;
   endfunction : sync_level

   function automatic code_t shift_left(input code_t c);
      if (c == CODE_ZERO)
         return CODE_ONE; // R18
      else if (c >= CODE_MID)
         return CODE_FULL; // R11 R17
      else
         return {c[CODE_W-2:0], 1'b0}; // R10
   endfunction : shift_left

   function automatic code_t inc_step(input code_t c);
      if (c == CODE_FULL)
         return CODE_FULL; // R21
      else
         return c + CODE_ONE; // R4
   endfunction : inc_step

   function automatic logic [TAP_COUNT-1:0] decode_tap(input code_t c);
      logic [TAP_COUNT-1:0] t;
      t = '0;
      t[c] = 1'b1; // R1 R2
      return t;
   endfunction : decode_tap

   // ==========================================
   // Next state
   always_comb
   begin
      core_next = core_reg;
      execNow = 1'b0;
      execCmd = core_reg.cmd;
      core_next.csSync = {core_reg.csSync[1:0], csN};
      core_next.togSync = {core_reg.togSync[1:0], frameTog};
      core_next.recSync = {core_reg.recSync[1:0], recallStrobeN};
      core_next.wpSync = {core_reg.wpSync[1:0], writeProtectN};
      core_next.csLvl = sync_level(core_reg.csSync, core_reg.csLvl);
      core_next.togLvl = sync_level(core_reg.togSync, core_reg.togLvl);
      core_next.recLvl = sync_level(core_reg.recSync, core_reg.recLvl);
      core_next.wpLvl = sync_level(core_reg.wpSync, core_reg.wpLvl);
      csRise = core_next.csLvl & ~core_reg.csLvl;
      recallFall = core_reg.recLvl & ~core_next.recLvl;
      newFrame = core_reg.togLvl != core_reg.togSeen;
      case (core_reg.state)
         ST_BOOT:
         begin
            core_next.wiper[0] = core_reg.nv[ADDR_CH1][CODE_W-1:0]; // R7
            core_next.wiper[1] = core_reg.nv[ADDR_CH2][CODE_W-1:0]; // R7
            core_next.state = ST_IDLE;
         end
         ST_IDLE:
         begin
            if (csRise)
            begin
               execNow = 1'b1; // R20
               if (newFrame)
               begin
                  execCmd = rxWord;
                  core_next.togSeen = core_reg.togLvl;
               end
            end
         end
         default:
         begin
            core_next.state = ST_BOOT;
         end
      endcase
      chSel = execCmd.addr[0];
      chValid = execCmd.addr[3:1] == 3'h0;
      userAddr = (execCmd.addr >= ADDR_USER_FIRST) && (execCmd.addr <= ADDR_USER_LAST);
      if (execNow)
      begin
         core_next.cmd = execCmd; // R19
         core_next.reply = execCmd; // R16
         case (execCmd.op)
            OP_NOP:
            begin
               core_next.readPower = 1'b0; // R14
            end
            OP_RECALL:
            begin
               if (chValid)
                  core_next.wiper[chSel] = core_reg.nv[execCmd.addr][CODE_W-1:0]; // R8
               core_next.readPower = 1'b1;
            end
            OP_SAVE:
            begin
               if (chValid && core_reg.wpLvl) // R6
                  core_next.nv[execCmd.addr] = {6'h00, core_reg.wiper[chSel]}; // R5
            end
            OP_USER_STORE:
            begin
               if (userAddr && core_reg.wpLvl) // R6
                  core_next.nv[execCmd.addr] = execCmd.data; // R12
            end
            OP_RECALL_ALL:
            begin
               core_next.wiper[0] = core_reg.nv[ADDR_CH1][CODE_W-1:0]; // R7
               core_next.wiper[1] = core_reg.nv[ADDR_CH2][CODE_W-1:0];
            end
            OP_READ_NV:
            begin
               core_next.reply.data = core_reg.nv[execCmd.addr]; // R13 R14
               core_next.readPower = 1'b1;
            end
            OP_READ_WIPER:
            begin
               if (chValid)
                  core_next.reply.data = {6'h00, core_reg.wiper[chSel]}; // R15
            end
            OP_WRITE_WIPER:
            begin
               if (chValid)
                  core_next.wiper[chSel] = execCmd.data[CODE_W-1:0]; // R3
            end
            OP_SHIFT_LEFT:
            begin
               if (chValid)
                  core_next.wiper[chSel] = shift_left(core_reg.wiper[chSel]); // R10
            end
            OP_INC_STEP:
            begin
               if (chValid)
                  core_next.wiper[chSel] = inc_step(core_reg.wiper[chSel]); // R4
            end
            default:
            begin
               core_next.reply = execCmd;
            end
         endcase
      end
      if (recallFall)
      begin
         core_next.wiper[0] = core_reg.nv[ADDR_CH1][CODE_W-1:0]; // R7
         core_next.wiper[1] = core_reg.nv[ADDR_CH2][CODE_W-1:0];
      end
      for (int i = 0; i < 2; i++)
      begin
         core_next.tap[i] = decode_tap(core_next.wiper[i]); // R1
      end
   end

   // ==========================================
   // State register
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         core_reg <= '0;
         core_reg.state <= ST_BOOT;
         core_reg.csSync <= SYNC_HIGH;
         core_reg.recSync <= SYNC_HIGH;
         core_reg.wpSync <= SYNC_LOW;
         core_reg.csLvl <= 1'b1;
         core_reg.recLvl <= 1'b1;
         core_reg.tap <= {TAP_RESET, TAP_RESET};
         core_reg.nv <= {TOLERANCE_RESET, {(NV_WORDS-1){NV_RESET}}};
      end
      else
      begin
         core_reg <= core_next;
      end
   end

   // ==========================================
   // Outputs
   assign wiperCode1 = core_reg.wiper[0];
   assign wiperCode2 = core_reg.wiper[1];
   assign tapSelect1 = core_reg.tap[0];
   assign tapSelect2 = core_reg.tap[1];
   assign readPowerActive = core_reg.readPower;

   // ==========================================
   // Checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence seqExecOn(logic [3:0] op, logic [3:0] ad);
      execNow && !recallFall && execCmd.op == op && execCmd.addr == ad;
   endsequence

   sequence seqWriteAllowed;
      core_reg.wpLvl;
   endsequence

   chk_tap_onehot: assert property ($onehot(core_reg.tap[0]) && $onehot(core_reg.tap[1])) // R1
      else $error("tap select not one-hot");
   chk_tap_position: assert property (tapSelect1[wiperCode1] && (tapSelect1[0] == (wiperCode1 == CODE_ZERO))) // R2
      else $error("tap does not follow code");
   chk_write_wiper: assert property (seqExecOn(OP_WRITE_WIPER, ADDR_CH2) |=> // R3
      wiperCode2 == $past(execCmd.data[CODE_W-1:0]) ##1 tapSelect2[$past(execCmd.data[CODE_W-1:0], 2)])
      else $error("wiper write lost");
   chk_inc_step: assert property (seqExecOn(OP_INC_STEP, ADDR_CH1) ##0 wiperCode1 != CODE_FULL |=> // R4
      wiperCode1 == $past(wiperCode1) + CODE_ONE)
      else $error("increment wrong");
   chk_inc_saturate: assert property (seqExecOn(OP_INC_STEP, ADDR_CH1) ##0 wiperCode1 == CODE_FULL |=> // R21
      wiperCode1 == CODE_FULL)
      else $error("increment wrapped");
   chk_save_word: assert property (seqExecOn(OP_SAVE, ADDR_CH1) ##0 seqWriteAllowed |=> // R5
      core_reg.nv[ADDR_CH1][CODE_W-1:0] == $past(wiperCode1))
      else $error("save lost");
   chk_protect_hold: assert property (execNow && !core_reg.wpLvl |=> $stable(core_reg.nv)) // R6
      else $error("write protect ignored");
   chk_recall_pin: assert property (recallFall |=> // R7
      wiperCode1 == $past(core_reg.nv[ADDR_CH1][CODE_W-1:0]) && wiperCode2 == $past(core_reg.nv[ADDR_CH2][CODE_W-1:0]))
      else $error("recall strobe ignored");
   chk_recall_cmd: assert property (seqExecOn(OP_RECALL, ADDR_CH1) |=> // R8
      wiperCode1 == $past(core_reg.nv[ADDR_CH1][CODE_W-1:0]) && readPowerActive)
      else $error("recall command wrong");
   chk_double_mid: assert property (seqExecOn(OP_SHIFT_LEFT, ADDR_CH1) ##0 wiperCode1 >= CODE_MID |=> // R11 R17
      wiperCode1 == CODE_FULL)
      else $error("doubling overflowed");
   chk_double_zero: assert property (seqExecOn(OP_SHIFT_LEFT, ADDR_CH2) ##0 wiperCode2 == CODE_ZERO |=> // R18
      wiperCode2 == CODE_ONE)
      else $error("doubling zero stuck");
   chk_double_mid_range: assert property (seqExecOn(OP_SHIFT_LEFT, ADDR_CH1) ##0 // R10
      (wiperCode1 != CODE_ZERO && wiperCode1 < CODE_MID) |=> wiperCode1 == {$past(wiperCode1[CODE_W-2:0]), 1'b0})
      else $error("doubling wrong");
   chk_user_store: assert property (seqExecOn(OP_USER_STORE, ADDR_USER_FIRST) ##0 seqWriteAllowed |=> // R12
      core_reg.nv[ADDR_USER_FIRST] == $past(execCmd.data))
      else $error("spare word store lost");
   chk_read_reply: assert property (execNow && execCmd.op == OP_READ_NV |=> // R13 R16
      core_reg.reply.data == $past(core_reg.nv[execCmd.addr]) && core_reg.reply.op == OP_READ_NV)
      else $error("read reply wrong");
   chk_wiper_reply: assert property (seqExecOn(OP_READ_WIPER, ADDR_CH1) |=> // R15
      core_reg.reply.data == {6'h00, $past(wiperCode1)})
      else $error("wiper readback wrong");
   chk_nop_idle: assert property (execNow && execCmd.op == OP_NOP |=> !readPowerActive) // R14
      else $error("no-op did not idle");
   chk_repeat_cmd: assert property (csRise && !newFrame && core_reg.state == ST_IDLE |-> // R19
      execNow && execCmd == core_reg.cmd)
      else $error("strobe did not repeat command");
endmodule : dual_pot_serial_command_core
`default_nettype wire

// ### bench/serial_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module serial_host_model
   import dual_pot_pkg::*;
   #(parameter int HALF_NS = 32)
(
   output var logic sclk,
   output var logic csN,
   output var logic sdi,
   input wire logic sdo
);
   // ==========================================
   // Idle levels, clock stands still low
   initial
   begin
      sclk = 1'b0;
      csN = 1'b1;
      sdi = 1'b0;
   end

   // ==========================================
   // One 24-bit frame, reply captured on rising edges
   task automatic xfer(input frame_s tx, output frame_s rx);
      logic [23:0] bits;
      logic [23:0] got;
      bits = tx;
      csN = 1'b0;
      sdi = bits[23];
      #(HALF_NS);
      for (int i = 23; i >= 0; i--)
      begin
         sclk = 1'b1;
         got[i] = sdo;
         #(HALF_NS);
         sclk = 1'b0;
         if (i > 0)
            sdi = bits[i-1];
         #(HALF_NS);
      end
      csN = 1'b1;
      sdi = ~sdi;
      rx = got;
   endtask : xfer

   // ==========================================
   // Select pulse with no clock edges
   task automatic strobe();
      csN = 1'b0;
      #(2*HALF_NS);
      csN = 1'b1;
      sdi = ~sdi;
   endtask : strobe
endmodule : serial_host_model
`default_nettype wire

// ### bench/dual_pot_serial_command_core_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHECK(what, exp, got) \
   begin \
      checksDone++; \
      if ((got) !== (exp)) \
      begin \
         numErrors++; \
         $display("ERROR %s expected %h got %h", what, exp, got); \
      end \
   end
module dual_pot_serial_command_core_tb
   import dual_pot_pkg::*;
   ;
   localparam logic [23:0] STROBE = 24'hFF_FFFF;
   localparam logic [23:0] PIN = 24'hFF_FFFE;
   localparam logic [23:0] WP_LO = 24'hFF_FFF0;
   localparam logic [23:0] WP_HI = 24'hFF_FFF1;
   localparam logic [23:0] DIR [44] = '{24'hB0_0100, 24'hB1_0200, 24'hE0_0000, 24'hE0_0000, 24'h20_0000,
      24'hB0_0005, 24'h10_0000, 24'h00_0000, 24'hC0_0000, 24'hC1_0000, 24'h32_AAAA, 24'h33_5555, 24'h92_0000,
      24'h00_0000, 24'hB0_0200, 24'hC0_0000, 24'hA0_0000, 24'h00_0000, 24'hB0_03FF, 24'hE0_0000, 24'hB0_0000,
      24'hC0_0000, 24'h40_0000, 24'h3F_1234, 24'h9F_0000, 24'h00_0000, 24'hB0_03FE, 24'hE0_0000, STROBE, STROBE,
      WP_LO, 24'h32_BEEF, 24'h20_0000, 24'h92_0000, WP_HI, 24'h00_0000, 24'hB1_0123, 24'h21_0000, 24'hB1_0000,
      24'hC1_0000, 24'h80_0000, 24'hB1_0000, PIN, 24'h00_0000};
   localparam logic [3:0] RAND_OPS [12] = '{OP_NOP, OP_RECALL, OP_SAVE, OP_USER_STORE, 4'h4, OP_READ_NV,
      OP_READ_WIPER, OP_WRITE_WIPER, OP_SHIFT_LEFT, 4'hD, OP_INC_STEP, OP_RECALL_ALL};
   logic clk, rst, sclk, csN, sdi, sdo, recallStrobeN, writeProtectN, readPowerActive;
   code_t wiperCode1, wiperCode2, m1, m2;
   logic [TAP_COUNT-1:0] tapSelect1, tapSelect2;
   logic [15:0] nv [NV_WORDS];
   logic rp;
   int numErrors, checksDone;
   frame_s lastCmd;
   frame_s expQ [$];

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   dual_pot_serial_command_core dut (.clk(clk), .rst(rst), .sclk(sclk), .csN(csN), .sdi(sdi), .sdo(sdo),
      .recallStrobeN(recallStrobeN), .writeProtectN(writeProtectN), .wiperCode1(wiperCode1),
      .wiperCode2(wiperCode2), .tapSelect1(tapSelect1), .tapSelect2(tapSelect2),
      .readPowerActive(readPowerActive));

   serial_host_model host (.sclk(sclk), .csN(csN), .sdi(sdi), .sdo(sdo));

   // ==========================================
   // Reference model
   function automatic code_t dbl(input code_t c);
      if (c == CODE_ZERO)
         return CODE_ONE;
      if (c >= CODE_MID)
         return CODE_FULL;
      return code_t'(c << 1);
   endfunction : dbl

   task automatic exec(input frame_s f);
      frame_s r;
      r = f;
      case (f.op)
         OP_NOP: rp = 1'b0;
         OP_RECALL:
         begin
            if (f.addr == ADDR_CH1)
               m1 = nv[0][9:0];
            if (f.addr == ADDR_CH2)
               m2 = nv[1][9:0];
            rp = 1'b1;
         end
         OP_SAVE:
         begin
            if (writeProtectN && f.addr == ADDR_CH1)
               nv[0] = {6'h00, m1};
            if (writeProtectN && f.addr == ADDR_CH2)
               nv[1] = {6'h00, m2};
         end
         OP_RECALL_ALL:
         begin
            m1 = nv[0][9:0];
            m2 = nv[1][9:0];
         end
         OP_USER_STORE:
            if (writeProtectN && f.addr >= ADDR_USER_FIRST && f.addr <= ADDR_USER_LAST)
               nv[f.addr] = f.data;
         OP_READ_NV:
         begin
            rp = 1'b1;
            r.data = nv[f.addr];
         end
         OP_READ_WIPER: r.data = {6'h00, m1};
         OP_WRITE_WIPER:
         begin
            if (f.addr == ADDR_CH1)
               m1 = f.data[9:0];
            if (f.addr == ADDR_CH2)
               m2 = f.data[9:0];
         end
         OP_SHIFT_LEFT:
         begin
            if (f.addr == ADDR_CH1)
               m1 = dbl(m1);
            if (f.addr == ADDR_CH2)
               m2 = dbl(m2);
         end
         OP_INC_STEP:
            if (f.addr == ADDR_CH1 && m1 != CODE_FULL)
               m1 = code_t'(m1 + 1);
         default: ;
      endcase
      lastCmd = f;
      expQ.delete();
      expQ.push_back(r);
   endtask : exec

   // ==========================================
   // Checks and stimulus steps
   task automatic checkState();
      `CHECK("wiperCode1", m1, wiperCode1)
      `CHECK("wiperCode2", m2, wiperCode2)
      `CHECK("tapSelect1", 1'b1, tapSelect1 === (TAP_RESET << m1))
      `CHECK("tapSelect2", 1'b1, tapSelect2 === (TAP_RESET << m2))
      `CHECK("readPowerActive", rp, readPowerActive)
   endtask : checkState

   task automatic step(input logic [23:0] v);
      frame_s rx;
      frame_s exp;
      case (v)
         STROBE:
         begin
            host.strobe();
            exec(lastCmd);
         end
         PIN:
         begin
            recallStrobeN = 1'b0;
            repeat (4) @(negedge clk);
            recallStrobeN = 1'b1;
            m1 = nv[0][9:0];
            m2 = nv[1][9:0];
         end
         WP_LO, WP_HI: writeProtectN = v[0];
         default:
         begin
            host.xfer(v, rx);
            if (expQ.size() > 0)
            begin
               exp = expQ.pop_front();
               `CHECK("reply", exp, rx)
            end
            exec(v);
         end
      endcase
      repeat (10) @(negedge clk);
      checkState();
   endtask : step

   task automatic completeRun();
      $display("checks %0d errors %0d", checksDone, numErrors);
      if (numErrors == 0 && checksDone > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : completeRun

   initial
   begin
      repeat (100000) @(posedge clk);
      numErrors++;
      $display("ERROR run expected done got timeout");
      completeRun();
   end

   // ==========================================
   // Main sequence
   initial
   begin
      frame_s f;
      rst = 1'b0;
      #1;
      rst = 1'b1;
      recallStrobeN = 1'b1;
      writeProtectN = 1'b1;
      numErrors = 0;
      checksDone = 0;
      rp = 1'b0;
      m1 = CODE_ZERO;
      m2 = CODE_ZERO;
      lastCmd = '0;
      foreach (nv[i])
         nv[i] = NV_RESET;
      nv[ADDR_TOLERANCE] = TOLERANCE_RESET;
      void'($urandom(62));
      repeat (3) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      repeat (2) @(negedge clk);
      checkState();
      foreach (DIR[i])
         step(DIR[i]);
      for (int n = 0; n < 60; n++)
      begin
         f.op = RAND_OPS[$urandom % 12];
         f.data = 16'($urandom);
         case (f.op)
            OP_RECALL, OP_SAVE: f.addr = 4'($urandom % 2);
            OP_WRITE_WIPER, OP_SHIFT_LEFT: f.addr = 4'($urandom % 3);
            OP_READ_WIPER, OP_INC_STEP: f.addr = ADDR_CH1;
            default: f.addr = 4'($urandom % 16);
         endcase
         writeProtectN = ($urandom % 4) != 0;
         step(f);
         if (f.op == OP_RECALL || f.op == OP_READ_NV)
            step(24'h00_0000);
         if ($urandom % 8 == 0)
            step(STROBE);
      end
      completeRun();
   end
endmodule : dual_pot_serial_command_core_tb
`default_nettype wire
